// File: include/fpep_pkg.sv
// Purpose: shared constants and types for the flash program/erase protection block
// Assumes: 8-bit register data, byte-wide register port
// Notes:   offsets are word indices on the plain register port

package fpep_pkg;

  // register offsets
  localparam logic [3:0] FPEP_OFF_CTRL_ONE  = 4'h0;
  localparam logic [3:0] FPEP_OFF_CTRL_TWO  = 4'h1;
  localparam logic [3:0] FPEP_OFF_EBS_ONE   = 4'h2;
  localparam logic [3:0] FPEP_OFF_EBS_TWO   = 4'h3;
  localparam logic [3:0] FPEP_OFF_RAM_EMU   = 4'h4;
  localparam logic [3:0] FPEP_OFF_IRQ_STAT  = 4'h5;
  localparam logic [3:0] FPEP_OFF_IRQ_MASK  = 4'h6;

  // flash_control_one fields
  localparam int FPEP_BIT_PROG = 0;
  localparam int FPEP_BIT_ERASE = 1;
  localparam int FPEP_BIT_SWE  = 6;
  // flash_control_two fields
  localparam int FPEP_BIT_FLASH_ERROR_FLAG = 7;
  // ram_emulation_register fields
  localparam int FPEP_BIT_RAM_OVERLAY_SELECT = 3;
  // interrupt status fields
  localparam int FPEP_BIT_IRQ_ERR  = 0;
  localparam int FPEP_BIT_IRQ_HWP  = 1;

  // reset values
  localparam logic [7:0] FPEP_RST_CTRL_ONE = 8'h00;
  localparam logic [7:0] FPEP_RST_CTRL_TWO = 8'h00;
  localparam logic [7:0] FPEP_RST_EBS      = 8'h00;
  localparam logic [7:0] FPEP_RST_RAM_EMU  = 8'h00;
  localparam logic [7:0] FPEP_RST_IRQ      = 8'h00;

  // error causes, ORed into the flag; the cause itself is not stored
  typedef struct packed {
    logic area_read;
    logic exception;
    logic sleep;
    logic bus_grant;
  } fpep_err_s;

  typedef enum logic [1:0] {
    FPEP_IDLE,
    FPEP_PROG,
    FPEP_ERASE,
    FPEP_ERRLOCK
  } fpep_state_e;

endpackage : fpep_pkg

// File: design/fpep_err_detect.sv
// Purpose: combines the error sources seen during a program or erase
// Assumes: all inputs synchronous to clk
// Notes:   purely combinational; the main module registers the result

`timescale 1ns/1ps
`default_nettype none

module fpep_err_detect
  import fpep_pkg::*;
(
  input  wire logic      busy,
  input  wire logic      flash_rd,
  input  wire logic      rd_in_area,
  input  wire logic      exc_start,
  input  wire logic      sleep_exec,
  input  wire logic      dma_grant,
  input  wire logic      dtc_grant,
  output fpep_err_s      cause,
  output logic           any_err
);

  // every cause only counts while an operation is running
  assign cause.area_read = busy & flash_rd & rd_in_area;
  assign cause.exception = busy & exc_start;
  assign cause.sleep     = busy & sleep_exec;
  assign cause.bus_grant = busy & (dma_grant | dtc_grant);
  assign any_err         = |cause;

endmodule : fpep_err_detect

`default_nettype wire

// File: design/fpep_top.sv
// Purpose: program/erase protection for on-chip flash, with control registers
// Assumes: reads return data in the cycle after the read strobe
// Notes:   standby input behaves as a synchronous hardware protection reset

`timescale 1ns/1ps
`default_nettype none

module fpep_top
  import fpep_pkg::*;
#(
  parameter int NBLK_ONE = 8,
  parameter int NBLK_TWO = 8
)
(
  input  wire logic                         clk,
  input  wire logic                         rstn,
  input  wire logic                         standby,
  input  wire logic [3:0]                   reg_addr,
  input  wire logic [7:0]                   reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [7:0]                   reg_rdata,
  input  wire logic                         flash_rd,
  input  wire logic                         rd_in_area,
  input  wire logic                         exc_start,
  input  wire logic                         sleep_exec,
  input  wire logic                         dma_grant,
  input  wire logic                         dtc_grant,
  output logic                              prog_active,
  output logic                              erase_active,
  output logic      [NBLK_ONE+NBLK_TWO-1:0] erase_blocks,
  output logic                              flash_error_flag,
  output logic                              irq
);

  logic [7:0]  flash_control_one_r;
  logic [7:0]  flash_control_two_r;
  logic [NBLK_ONE-1:0] erase_block_select_one_r;
  logic [NBLK_TWO-1:0] erase_block_select_two_r;
  logic [7:0]  ram_emulation_register_r;
  logic [7:0]  irq_stat_r;
  logic [7:0]  irq_mask_r;
  logic [7:0]  rdata_r;
  fpep_state_e state_r;
  fpep_state_e state_nxt;
  fpep_err_s   cause;
  logic        any_err;
  logic        err_set;
  logic        standby_q_r;

  // one address compare shared by every write strobe
  function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] off);
    reg_hit = (addr == off);
  endfunction : reg_hit

  // register decode
  wire wr_c1  = reg_wr & reg_hit(reg_addr, FPEP_OFF_CTRL_ONE);
  wire wr_e1  = reg_wr & reg_hit(reg_addr, FPEP_OFF_EBS_ONE);
  wire wr_e2  = reg_wr & reg_hit(reg_addr, FPEP_OFF_EBS_TWO);
  wire wr_ram = reg_wr & reg_hit(reg_addr, FPEP_OFF_RAM_EMU);
  wire wr_ist = reg_wr & reg_hit(reg_addr, FPEP_OFF_IRQ_STAT);
  wire wr_imk = reg_wr & reg_hit(reg_addr, FPEP_OFF_IRQ_MASK);

  // protection terms
  wire software_write_enable = flash_control_one_r[FPEP_BIT_SWE];
  wire program_mode_bit      = flash_control_one_r[FPEP_BIT_PROG];
  wire erase_mode_bit        = flash_control_one_r[FPEP_BIT_ERASE];
  wire ram_overlay_select    = ram_emulation_register_r[FPEP_BIT_RAM_OVERLAY_SELECT];
  wire [NBLK_ONE+NBLK_TWO-1:0] blk_sel = {erase_block_select_two_r, erase_block_select_one_r};
  wire any_sel   = |blk_sel;
  // overlay and cleared write enable each block everything
  wire sw_allow  = software_write_enable & ~ram_overlay_select;
  wire err_lock  = (state_r == FPEP_ERRLOCK);
  wire busy      = (state_r == FPEP_PROG) | (state_r == FPEP_ERASE);

  fpep_err_detect u_err (
    .busy       (busy),
    .flash_rd   (flash_rd),
    .rd_in_area (rd_in_area),
    .exc_start  (exc_start),
    .sleep_exec (sleep_exec),
    .dma_grant  (dma_grant),
    .dtc_grant  (dtc_grant),
    .cause      (cause),
    .any_err    (any_err)
  );

  assign err_set = any_err;

  // mode sequencer; standby acts ahead of everything
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      FPEP_IDLE: begin
        if (sw_allow && program_mode_bit) begin
          state_nxt = FPEP_PROG;
        end else if (sw_allow && erase_mode_bit && (|blk_sel)) begin
          state_nxt = FPEP_ERASE;
        end
      end
      FPEP_PROG: begin
        if (err_set) state_nxt = FPEP_ERRLOCK;
        else if (!sw_allow || !program_mode_bit) state_nxt = FPEP_IDLE;
      end
      FPEP_ERASE: begin
        if (err_set) state_nxt = FPEP_ERRLOCK;
        else if (!sw_allow || !erase_mode_bit || !(|blk_sel)) state_nxt = FPEP_IDLE;
      end
      FPEP_ERRLOCK: state_nxt = FPEP_ERRLOCK;
      default:      state_nxt = FPEP_IDLE;
    endcase
    if (standby) state_nxt = FPEP_IDLE;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) state_r <= FPEP_IDLE;
    else       state_r <= state_nxt;
  end

  // control registers; standby restores them like reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flash_control_one_r      <= FPEP_RST_CTRL_ONE;
      flash_control_two_r      <= FPEP_RST_CTRL_TWO;
      erase_block_select_one_r <= NBLK_ONE'(FPEP_RST_EBS);
      erase_block_select_two_r <= NBLK_TWO'(FPEP_RST_EBS);
    end else if (standby) begin
      flash_control_one_r      <= FPEP_RST_CTRL_ONE;
      flash_control_two_r      <= FPEP_RST_CTRL_TWO;
      erase_block_select_one_r <= NBLK_ONE'(FPEP_RST_EBS);
      erase_block_select_two_r <= NBLK_TWO'(FPEP_RST_EBS);
    end else begin
      if (wr_c1) flash_control_one_r <= reg_wdata;
      if (wr_e1) erase_block_select_one_r <= reg_wdata[NBLK_ONE-1:0];
      if (wr_e2) erase_block_select_two_r <= reg_wdata[NBLK_TWO-1:0];
      // the flag is hardware-only; software cannot clear it
      if (err_set) flash_control_two_r[FPEP_BIT_FLASH_ERROR_FLAG] <= 1'b1;
    end
  end

  // ram emulation register is not a flash control, so standby leaves it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)       ram_emulation_register_r <= FPEP_RST_RAM_EMU;
    else if (wr_ram) ram_emulation_register_r <= reg_wdata;
  end

  // sticky events: error entry and standby abort; set wins over clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_stat_r  <= FPEP_RST_IRQ;
      irq_mask_r  <= FPEP_RST_IRQ;
      standby_q_r <= 1'b0;
    end else begin
      standby_q_r <= standby;
      irq_stat_r  <= (irq_stat_r & ~(wr_ist ? reg_wdata : 8'h00))
                   | {6'h00, standby & ~standby_q_r & busy, err_set};
      if (wr_imk) irq_mask_r <= reg_wdata;
    end
  end

  // read mux, registered for the one-cycle read latency
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) rdata_r <= 8'h00;
    else if (reg_rd) begin
      case (reg_addr)
        FPEP_OFF_CTRL_ONE: rdata_r <= flash_control_one_r;
        FPEP_OFF_CTRL_TWO: rdata_r <= flash_control_two_r;
        FPEP_OFF_EBS_ONE:  rdata_r <= 8'(erase_block_select_one_r);
        FPEP_OFF_EBS_TWO:  rdata_r <= 8'(erase_block_select_two_r);
        FPEP_OFF_RAM_EMU:  rdata_r <= ram_emulation_register_r;
        FPEP_OFF_IRQ_STAT: rdata_r <= irq_stat_r;
        FPEP_OFF_IRQ_MASK: rdata_r <= irq_mask_r;
        default:           rdata_r <= 8'h00;
      endcase
    end else rdata_r <= 8'h00;
  end

  // outputs; erase only ever reaches selected blocks
  assign reg_rdata        = rdata_r;
  assign prog_active      = (state_r == FPEP_PROG);
  assign erase_active     = (state_r == FPEP_ERASE);
  assign erase_blocks     = erase_active ? blk_sel : '0;
  assign flash_error_flag = flash_control_two_r[FPEP_BIT_FLASH_ERROR_FLAG];
  assign irq              = |(irq_stat_r & irq_mask_r);

  property p_no_op_without_swe;
    @(posedge clk) disable iff (!rstn)
      !software_write_enable |=> !(prog_active || erase_active);
  endproperty
  a_no_op_without_swe: assert property (p_no_op_without_swe) else $error("op without enable");

  property p_no_op_under_overlay;
    @(posedge clk) disable iff (!rstn)
      ram_overlay_select |=> !(prog_active || erase_active);
  endproperty
  a_no_op_under_overlay: assert property (p_no_op_under_overlay) else $error("op under overlay");

  property p_mode_bit_ignored;
    @(posedge clk) disable iff (!rstn)
      (state_r == FPEP_IDLE && !sw_allow && program_mode_bit) |=> !prog_active;
  endproperty
  a_mode_bit_ignored: assert property (p_mode_bit_ignored) else $error("mode entered");

  property p_erase_selected_only;
    @(posedge clk) disable iff (!rstn)
      erase_active |-> ((erase_blocks & ~blk_sel) == '0) && (|blk_sel);
  endproperty
  a_erase_selected_only: assert property (p_erase_selected_only) else $error("bad block");

  property p_zero_select_blocks;
    @(posedge clk) disable iff (!rstn)
      (blk_sel == '0) |=> !erase_active;
  endproperty
  a_zero_select_blocks: assert property (p_zero_select_blocks) else $error("erase no select");

  property p_error_sets_flag;
    @(posedge clk) disable iff (!rstn)
      (busy && any_err && !standby) |=> flash_error_flag && err_lock;
  endproperty
  a_error_sets_flag: assert property (p_error_sets_flag) else $error("flag not set");

  property p_error_aborts;
    @(posedge clk) disable iff (!rstn)
      (busy && any_err) |=> !(prog_active || erase_active);
  endproperty
  a_error_aborts: assert property (p_error_aborts) else $error("not aborted");

  property p_sleep_error;
    @(posedge clk) disable iff (!rstn)
      (prog_active && sleep_exec && !standby) |=> $rose(flash_error_flag) || $past(flash_error_flag);
  endproperty
  a_sleep_error: assert property (p_sleep_error) else $error("sleep missed");

  property p_lock_holds;
    @(posedge clk) disable iff (!rstn)
      (err_lock && !standby) |=> err_lock && flash_error_flag && !prog_active;
  endproperty
  a_lock_holds: assert property (p_lock_holds) else $error("lock lost");

  property p_standby_clears;
    @(posedge clk) disable iff (!rstn)
      standby |=> state_r == FPEP_IDLE && !flash_error_flag && flash_control_one_r == 8'h00;
  endproperty
  a_standby_clears: assert property (p_standby_clears) else $error("standby no clear");

  // per-cause checks; standby in the same cycle wins over an error
  property p_cause_only_busy;
    @(posedge clk) disable iff (!rstn)
      (cause != '0) |-> busy;
  endproperty
  a_cause_only_busy: assert property (p_cause_only_busy) else $error("cause while idle");

  property p_area_read_error;
    @(posedge clk) disable iff (!rstn)
      (busy && flash_rd && rd_in_area && !standby) |=> flash_error_flag;
  endproperty
  a_area_read_error: assert property (p_area_read_error) else $error("area read missed");

  property p_exception_error;
    @(posedge clk) disable iff (!rstn)
      (busy && exc_start && !standby) |=> flash_error_flag;
  endproperty
  a_exception_error: assert property (p_exception_error) else $error("exception missed");

  property p_dma_grant_error;
    @(posedge clk) disable iff (!rstn)
      (busy && dma_grant && !standby) |=> flash_error_flag;
  endproperty
  a_dma_grant_error: assert property (p_dma_grant_error) else $error("dma grant missed");

  property p_dtc_grant_error;
    @(posedge clk) disable iff (!rstn)
      (busy && dtc_grant && !standby) |=> flash_error_flag;
  endproperty
  a_dtc_grant_error: assert property (p_dtc_grant_error) else $error("dtc grant missed");

  property p_flag_needs_error;
    @(posedge clk) disable iff (!rstn)
      (!flash_error_flag && !err_set) |=> !flash_error_flag;
  endproperty
  a_flag_needs_error: assert property (p_flag_needs_error) else $error("flag without error");

  property p_standby_stops;
    @(posedge clk) disable iff (!rstn)
      standby |=> !(prog_active || erase_active);
  endproperty
  a_standby_stops: assert property (p_standby_stops) else $error("standby no stop");

  property p_standby_clears_selects;
    @(posedge clk) disable iff (!rstn)
      standby |=> (blk_sel == '0) && (flash_control_two_r == FPEP_RST_CTRL_TWO);
  endproperty
  a_standby_clears_selects: assert property (p_standby_clears_selects) else $error("sel kept");

  property p_idle_no_blocks;
    @(posedge clk) disable iff (!rstn)
      !erase_active |-> (erase_blocks == '0);
  endproperty
  a_idle_no_blocks: assert property (p_idle_no_blocks) else $error("blocks while idle");

  property p_prog_needs_enable;
    @(posedge clk) disable iff (!rstn)
      prog_active |-> $past(sw_allow) && $past(program_mode_bit);
  endproperty
  a_prog_needs_enable: assert property (p_prog_needs_enable) else $error("prog no enable");

  property p_erase_needs_select;
    @(posedge clk) disable iff (!rstn)
      erase_active |-> $past(sw_allow) && $past(erase_mode_bit) && $past(any_sel);
  endproperty
  a_erase_needs_select: assert property (p_erase_needs_select) else $error("erase no sel");

  // status capture must survive a clear written in the same cycle
  property p_err_event_recorded;
    @(posedge clk) disable iff (!rstn)
      err_set |=> irq_stat_r[FPEP_BIT_IRQ_ERR];
  endproperty
  a_err_event_recorded: assert property (p_err_event_recorded) else $error("err not latched");

  property p_abort_recorded;
    @(posedge clk) disable iff (!rstn)
      (standby && !standby_q_r && busy) |=> irq_stat_r[FPEP_BIT_IRQ_HWP];
  endproperty
  a_abort_recorded: assert property (p_abort_recorded) else $error("abort not latched");

  property p_lock_outputs_off;
    @(posedge clk) disable iff (!rstn)
      err_lock |-> !prog_active && !erase_active && (erase_blocks == '0);
  endproperty
  a_lock_outputs_off: assert property (p_lock_outputs_off) else $error("locked op");

endmodule : fpep_top

`default_nettype wire

// File: test/fpep_cpu_model.sv
// Purpose: cpu-side model that raises the protection error events on command
// Assumes: bench sets kind and pulses fire for one clock
// Notes:   every event lasts one cycle; all lines idle low

`timescale 1ns/1ps
`default_nettype none

module fpep_cpu_model (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       fire,
  input  wire logic [2:0] kind,
  output logic            flash_rd,
  output logic            rd_in_area,
  output logic            exc_start,
  output logic            sleep_exec,
  output logic            dma_grant,
  output logic            dtc_grant
);
  // one-cycle event; grants drop again so no stale bus hand-off lingers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {flash_rd, rd_in_area, exc_start, sleep_exec, dma_grant, dtc_grant} <= 6'h00;
    end else begin
      flash_rd   <= fire && kind == 3'h0;
      rd_in_area <= fire && kind == 3'h0;
      exc_start  <= fire && kind == 3'h1;
      sleep_exec <= fire && kind == 3'h2;
      dma_grant  <= fire && kind == 3'h3;
      dtc_grant  <= fire && kind == 3'h4;
    end
  end
endmodule : fpep_cpu_model

`default_nettype wire

// File: test/fpep_top_bench.sv
// Purpose: self-checking bench for the flash program/erase protection block
// Assumes: one 200 MHz clock, read data one cycle after the strobe
// Notes:   error events come from the cpu model, registers from the tasks here

`timescale 1ns/1ps
`default_nettype none

module fpep_top_bench
  import fpep_pkg::*;
;
  logic        clk, rstn, standby, reg_wr, reg_rd, fire;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [2:0]  kind;
  logic        flash_rd, rd_in_area, exc_start, sleep_exec, dma_grant, dtc_grant;
  logic        prog_active, erase_active, flash_error_flag, irq;
  logic [15:0] erase_blocks;
  int          err_count = 0;
  int          num_checks = 0;

  fpep_top #(.NBLK_ONE(8), .NBLK_TWO(8)) dut (.clk, .rstn, .standby, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .flash_rd, .rd_in_area, .exc_start, .sleep_exec,
    .dma_grant, .dtc_grant, .prog_active, .erase_active, .erase_blocks, .flash_error_flag, .irq);
  fpep_cpu_model cpu (.clk, .rstn, .fire, .kind, .flash_rd, .rd_in_area, .exc_start,
    .sleep_exec, .dma_grant, .dtc_grant);

  // 5 ns clock
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'h1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'h0;
  endtask : wr

  // read data stands only in the cycle after the strobe, so sample there
  task automatic rchk(input string what, input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd   <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'h0;
    #1;
    chk(what, {8'h00, reg_rdata}, {8'h00, exp});
  endtask : rchk

  task automatic pulse_stby();
    @(posedge clk);
    standby <= 1'h1;
    @(posedge clk);
    standby <= 1'h0;
  endtask : pulse_stby

  task automatic t_regs();
    for (int i = 0; i < 8; i++) rchk("reg", 4'(i), 8'h00);
    wr(FPEP_OFF_CTRL_TWO, 8'hFF);
    rchk("ctrl_two", FPEP_OFF_CTRL_TWO, 8'h00);
    rchk("unmapped", 4'hF, 8'h00);
  endtask : t_regs

  task automatic t_soft();
    wr(FPEP_OFF_EBS_ONE, 8'h05);
    wr(FPEP_OFF_CTRL_ONE, 8'h01);
    settle(1);
    chk("prog_nowe", prog_active, 16'h0000);
    wr(FPEP_OFF_CTRL_ONE, 8'h02);
    settle(1);
    chk("erase_nowe", erase_active, 16'h0000);
    wr(FPEP_OFF_CTRL_ONE, 8'h41);
    settle(1);
    chk("prog_we", prog_active, 16'h0001);
    wr(FPEP_OFF_CTRL_ONE, 8'h01);
    settle(1);
    chk("prog_weoff", prog_active, 16'h0000);
  endtask : t_soft

  task automatic t_sel();
    wr(FPEP_OFF_EBS_ONE, 8'h00);
    wr(FPEP_OFF_CTRL_ONE, 8'h42);
    settle(1);
    chk("erase_nosel", erase_active, 16'h0000);
    chk("blocks_nosel", erase_blocks, 16'h0000);
    wr(FPEP_OFF_CTRL_ONE, 8'h00);
    wr(FPEP_OFF_EBS_ONE, 8'h05);
    wr(FPEP_OFF_EBS_TWO, 8'h80);
    wr(FPEP_OFF_CTRL_ONE, 8'h42);
    settle(1);
    chk("erase_sel", erase_active, 16'h0001);
    chk("blocks_sel", erase_blocks, 16'h8005);
    wr(FPEP_OFF_CTRL_ONE, 8'h00);
    wr(FPEP_OFF_RAM_EMU, 8'h08);
    wr(FPEP_OFF_CTRL_ONE, 8'h41);
    settle(1);
    chk("prog_ovl", prog_active, 16'h0000);
    wr(FPEP_OFF_CTRL_ONE, 8'h42);
    settle(1);
    chk("erase_ovl", erase_active, 16'h0000);
    wr(FPEP_OFF_CTRL_ONE, 8'h00);
    wr(FPEP_OFF_RAM_EMU, 8'h00);
  endtask : t_sel

  // both mode bits: program wins; overlay set mid-program drops back to idle
  task automatic t_prio();
    wr(FPEP_OFF_CTRL_ONE, 8'h43);
    settle(1);
    chk("prog_both", prog_active, 16'h0001);
    chk("erase_both", erase_active, 16'h0000);
    wr(FPEP_OFF_RAM_EMU, 8'h08);
    settle(1);
    chk("prog_ovl_mid", prog_active, 16'h0000);
    wr(FPEP_OFF_CTRL_ONE, 8'h00);
    wr(FPEP_OFF_RAM_EMU, 8'h00);
  endtask : t_prio

  // first pass aborts an erase, the rest a program; each cause in turn
  task automatic t_err();
    wr(FPEP_OFF_IRQ_MASK, 8'h01);
    for (int k = 0; k < 5; k++) begin
      wr(FPEP_OFF_CTRL_ONE, (k == 0) ? 8'h42 : 8'h41);
      settle(1);
      chk("busy", prog_active | erase_active, 16'h0001);
      @(posedge clk);
      kind <= 3'(k);
      fire <= 1'h1;
      @(posedge clk);
      fire <= 1'h0;
      settle(1);
      chk("busy_abort", prog_active | erase_active, 16'h0000);
      chk("err_flag", flash_error_flag, 16'h0001);
      wr(FPEP_OFF_CTRL_ONE, 8'h41);
      settle(1);
      chk("prog_locked", prog_active, 16'h0000);
      rchk("ctrl_two", FPEP_OFF_CTRL_TWO, 8'h80);
      chk("irq_err", irq, 16'h0001);
      pulse_stby();
      settle(1);
      chk("err_flag_clr", flash_error_flag, 16'h0000);
      rchk("sel_one", FPEP_OFF_EBS_ONE, 8'h00);
      wr(FPEP_OFF_IRQ_STAT, 8'h03);
      settle(1);
      chk("irq_clr", irq, 16'h0000);
    end
  endtask : t_err

  // standby and reset both stop a running program
  task automatic t_hw();
    wr(FPEP_OFF_IRQ_MASK, 8'h00);
    wr(FPEP_OFF_CTRL_ONE, 8'h41);
    pulse_stby();
    settle(1);
    chk("prog_stby", prog_active, 16'h0000);
    rchk("ctrl_one", FPEP_OFF_CTRL_ONE, 8'h00);
    rchk("stat", FPEP_OFF_IRQ_STAT, 8'h02);
    chk("irq_masked", irq, 16'h0000);
    wr(FPEP_OFF_IRQ_MASK, 8'h02);
    settle(1);
    chk("irq_on", irq, 16'h0001);
    wr(FPEP_OFF_IRQ_STAT, 8'h02);
    settle(1);
    chk("irq_off", irq, 16'h0000);
    wr(FPEP_OFF_CTRL_ONE, 8'h41);
    settle(1);
    chk("prog_pre_rst", prog_active, 16'h0001);
    // reset edges are driven on the clock edge like every other input
    @(posedge clk);
    rstn <= 1'h0;
    settle(2);
    chk("prog_rst", prog_active, 16'h0000);
    @(posedge clk);
    rstn <= 1'h1;
    rchk("ctrl_one_rst", FPEP_OFF_CTRL_ONE, 8'h00);
  endtask : t_hw

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    stop_test();
  end

  initial begin
    {rstn, standby, reg_wr, reg_rd, fire} = 5'h00;
    reg_addr  = 4'h0;
    reg_wdata = 8'h00;
    kind      = 3'h0;
    repeat (12) @(posedge clk);
    rstn <= 1'h1;
    t_regs();
    t_soft();
    t_sel();
    t_prio();
    t_err();
    t_hw();
    stop_test();
  end
endmodule : fpep_top_bench

`default_nettype wire
